// ### include/rtcc_pkg.sv
package rtcc_pkg;
	// Host register map
	localparam logic [15:0] REG_TERMINAL_CONFIGURATION = 16'h0017;
	localparam logic [15:0] TABLE_FIRST_ADDR           = 16'h0200;
	localparam logic [15:0] TABLE_LAST_ADDR            = 16'h02ff;
	localparam logic [15:0] CFG_RESET                  = 16'h0000;
	localparam int          CFG_BROADCAST_INVALID_POS  = 7;
	localparam int          CFG_UNDEFINED_INVALID_POS  = 6;

	// Command word fields
	localparam int CMD_ADDR_MSB = 15;
	localparam int CMD_ADDR_LSB = 11;
	localparam int CMD_TR_POS   = 10;
	localparam int CMD_SA_MSB   = 9;
	localparam int CMD_SA_LSB   = 5;
	localparam int CMD_WC_MSB   = 4;
	localparam int CMD_WC_LSB   = 0;

	// Addresses, subaddresses and mode code numbers
	localparam logic [4:0] BROADCAST_TERMINAL_ADDRESS = 5'h1f;
	localparam logic [4:0] MODE_SA_LOW                = 5'h00;
	localparam logic [4:0] MODE_SA_HIGH               = 5'h1f;
	localparam logic [4:0] MODE_CODE_SIXTEEN          = 5'h10;
	localparam logic [4:0] MODE_CODE_17               = 5'h11;
	localparam logic [4:0] MODE_CODE_18               = 5'h12;
	localparam logic [4:0] MODE_CODE_19               = 5'h13;
	localparam logic [4:0] MODE_CODE_20               = 5'h14;
	localparam logic [4:0] MODE_CODE_21               = 5'h15;
	localparam logic [4:0] RESERVED_LOW_FIRST         = 5'h09;
	localparam logic [4:0] RESERVED_HIGH_FIRST        = 5'h16;
	localparam logic [4:0] WORD_COUNT_FULL_CODE       = 5'h00;
	localparam logic [5:0] WORD_COUNT_FULL            = 6'h20;
	localparam logic [5:0] MODE_DATA_ONE              = 6'h01;
	localparam logic [5:0] NO_WORDS                   = 6'h00;

	// Legality table geometry
	localparam int         TABLE_DEPTH      = 256;
	localparam int         TABLE_AW         = 8;
	localparam logic [7:0] TABLE_LAST_INDEX = 8'hff;
	localparam logic [15:0] TABLE_CLEAR     = 16'h0000;

	// Timing
	localparam int CLK_PERIOD_NS = 5;

	typedef enum logic [1:0] {
		ST_CLEAR,
		ST_IDLE,
		ST_LOOKUP,
		ST_DECIDE
	} rtcc_state_t;
endpackage : rtcc_pkg

// ### logic/rtcc_legality_table.sv
`timescale 1ns/1ps
module rtcc_legality_table
	import rtcc_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                write_en,
	input  wire logic [TABLE_AW-1:0] write_index,
	input  wire logic [15:0]         write_data,
	input  wire logic [TABLE_AW-1:0] lookup_index,
	output logic      [15:0]         lookup_data,
	input  wire logic [TABLE_AW-1:0] host_index,
	output logic      [15:0]         host_data
);
	// No reset on the array; the owner sweeps it to zero after reset
	logic [15:0] table_mem [TABLE_DEPTH];

	// Single write port shared by the clear sweep and the host
	always_ff @(posedge clk) begin
		if (write_en) begin
			table_mem[write_index] <= write_data;
		end
	end

	// Two registered read ports, classifier and host
	always_ff @(posedge clk) begin
		lookup_data <= table_mem[lookup_index];
		host_data   <= table_mem[host_index];
	end
endmodule : rtcc_legality_table

// ### logic/rtcc_classifier.sv
`timescale 1ns/1ps
// Overview of operation
// - Accept commands to own latched address or to broadcast address 31.
// - Broadcast-invalid bit set: address 31 commands ignored, no response.
// - Subaddress 1..30 is a subaddress command; direction from T/R bit.
// - Subaddress word count 1..32; field zero means 32 words.
// - Subaddress 0 or 31 is a mode command; low bits are mode code.
// - Mode codes 16..31 carry one data word, received or transmitted by T/R.
// - Mode codes 0..15 with T/R zero are undefined.
// - Undefined: 0..15 and 16,18,19 with T/R 0; 17,20,21 with T/R 1.
// - Undefined-invalid bit set: undefined modes ignored, status untouched.
// - Undefined-invalid bit clear (reset value): undefined modes valid, table decides.
// - Table zero: clear status, words in form, status updated.
// - Table one: status with message error only, no data on transmit, status updated.
// - Reserved: 9..15 with T/R 1, 22..31 any direction; table decides.
// - Legality table cleared to zero after reset.
// - Each transmit and receive subaddress has its own descriptor block.
// - Mode data words use a fixed address per mode code and T/R bit.
// - Terminal pair: receive command first, then transmit, never to 31.
// - Pair with a mode subaddress in either word is ignored.
// - Pair receiving here, transmitter elsewhere: receive and flag pair.
// - Pair transmitting here: treated as an ordinary transmit command.
// - Each valid command fetches one bit from the 256-word table.
module rtcc_classifier
	import rtcc_pkg::*;
#(
	parameter logic [15:0] MODE_DATA_BASE = 16'h0000
)
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [4:0]  rt_address_pins,
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_word,
	input  wire logic        cmd_pair,
	input  wire logic [15:0] cmd_word2,
	input  wire logic [15:0] host_addr,
	input  wire logic        host_write,
	input  wire logic        host_read,
	input  wire logic [15:0] host_wdata,
	output logic      [15:0] host_rdata,
	output logic             host_rdata_valid,
	output logic             terminal_ready,
	output logic             cmd_ready,
	output logic             result_valid,
	output logic             accepted,
	output logic             status_update,
	output logic             message_error,
	output logic             transmit_dir,
	output logic             mode_command,
	output logic      [4:0]  mode_code,
	output logic             undefined_mode,
	output logic             reserved_mode,
	output logic             broadcast,
	output logic             terminal_to_terminal_flag,
	output logic      [5:0]  word_count,
	output logic      [5:0]  descriptor_index,
	output logic             mode_data_used,
	output logic      [15:0] mode_data_address
);
	// Field helpers
	function automatic logic [4:0] f_addr(input logic [15:0] w);
		return w[CMD_ADDR_MSB:CMD_ADDR_LSB];
	endfunction : f_addr

	function automatic logic f_tr(input logic [15:0] w);
		return w[CMD_TR_POS];
	endfunction : f_tr

	function automatic logic [4:0] f_sa(input logic [15:0] w);
		return w[CMD_SA_MSB:CMD_SA_LSB];
	endfunction : f_sa

	function automatic logic [4:0] f_wc(input logic [15:0] w);
		return w[CMD_WC_MSB:CMD_WC_LSB];
	endfunction : f_wc

	function automatic logic is_mode(input logic [4:0] sa);
		return (sa == MODE_SA_LOW) || (sa == MODE_SA_HIGH);
	endfunction : is_mode

	function automatic logic is_undefined(input logic tr, input logic [4:0] mc);
		logic low;
		logic rx_data;
		logic tx_data;
		low     = mc < MODE_CODE_SIXTEEN;
		rx_data = (mc == MODE_CODE_SIXTEEN) || (mc == MODE_CODE_18) || (mc == MODE_CODE_19);
		tx_data = (mc == MODE_CODE_17) || (mc == MODE_CODE_20) || (mc == MODE_CODE_21);
		return tr ? tx_data : (low || rx_data);
	endfunction : is_undefined

	function automatic logic is_reserved(input logic tr, input logic [4:0] mc);
		logic low_tx;
		low_tx = tr && (mc >= RESERVED_LOW_FIRST) && (mc < MODE_CODE_SIXTEEN);
		return low_tx || (mc >= RESERVED_HIGH_FIRST);
	endfunction : is_reserved

	function automatic logic [5:0] to_count(input logic [4:0] wc);
		return (wc == WORD_COUNT_FULL_CODE) ? WORD_COUNT_FULL : {1'b0, wc};
	endfunction : to_count

	rtcc_state_t          state;
	logic [15:0]          terminal_configuration;
	logic [4:0]           addr_meta;
	logic [4:0]           addr_sync;
	logic [4:0]           own_address;
	logic [TABLE_AW-1:0]  clear_index;
	logic [15:0]          held_word;
	logic                 held_valid;
	logic                 held_terminal_to_terminal_flag;
	logic [TABLE_AW-1:0]  lookup_index;
	logic [15:0]          lookup_data;
	logic [15:0]          table_host_data;
	logic                 read_pending;
	logic                 read_table;
	logic [15:0]          read_config;
	logic                 take;
	logic                 cfg_bcast_inv;
	logic                 cfg_undef_inv;
	logic                 host_in_table;
	logic                 table_write_en;
	logic [TABLE_AW-1:0]  table_write_index;
	logic [15:0]          table_write_data;
	logic [15:0]          next_word;
	logic                 next_valid;
	logic                 next_terminal_to_terminal_flag;
	logic                 held_mode;
	logic                 held_tr;
	logic [4:0]           held_wc;
	logic                 legal_bit;

	assign cfg_bcast_inv = terminal_configuration[CFG_BROADCAST_INVALID_POS];
	assign cfg_undef_inv = terminal_configuration[CFG_UNDEFINED_INVALID_POS];
	assign take          = cmd_valid && cmd_ready;
	assign host_in_table = (host_addr >= TABLE_FIRST_ADDR) && (host_addr <= TABLE_LAST_ADDR);
	assign held_mode     = is_mode(f_sa(held_word));
	assign held_tr       = f_tr(held_word);
	assign held_wc       = f_wc(held_word);
	assign legal_bit     = lookup_data[held_wc[3:0]];

	// Address matching; broadcast matches only while allowed
	function automatic logic addressed(input logic [4:0] a, input logic [4:0] own,
					   input logic bcast_inv);
		return (a == BROADCAST_TERMINAL_ADDRESS) ? !bcast_inv : (a == own);
	endfunction : addressed

	// Terminal address pins cross into the clock domain
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_meta <= 5'h00;
			addr_sync <= 5'h00;
		end else begin
			addr_meta <= rt_address_pins;
			addr_sync <= addr_meta;
		end
	end

	// Latch own address once, when the clear sweep finishes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			own_address <= 5'h00;
		end else if (state == ST_CLEAR && clear_index == TABLE_LAST_INDEX) begin
			own_address <= addr_sync;
		end
	end

	// Configuration register, host writable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			terminal_configuration <= CFG_RESET;
		end else if (host_write && host_addr == REG_TERMINAL_CONFIGURATION) begin
			terminal_configuration <= host_wdata;
		end
	end

	// Clear sweep owns the table write port until ready
	always_comb begin
		if (state == ST_CLEAR) begin
			table_write_en    = 1'b1;
			table_write_index = clear_index;
			table_write_data  = TABLE_CLEAR;
		end else begin
			table_write_en    = host_write && host_in_table;
			table_write_index = host_addr[TABLE_AW-1:0];
			table_write_data  = host_wdata;
		end
	end

	// Command classification on the take cycle
	always_comb begin
		next_word  = cmd_word;
		next_terminal_to_terminal_flag  = 1'b0;
		next_valid = 1'b0;
		if (cmd_pair) begin
			if (f_tr(cmd_word) || !f_tr(cmd_word2)
			    || f_addr(cmd_word2) == BROADCAST_TERMINAL_ADDRESS) begin
				next_valid = 1'b0;
			end else if (is_mode(f_sa(cmd_word)) || is_mode(f_sa(cmd_word2))) begin
				next_valid = 1'b0;
			end else if (f_addr(cmd_word2) == own_address) begin
				next_word  = cmd_word2;
				next_valid = 1'b1;
			end else begin
				next_terminal_to_terminal_flag  = 1'b1;
				next_valid = addressed(f_addr(cmd_word), own_address, cfg_bcast_inv);
			end
		end else begin
			next_valid = addressed(f_addr(cmd_word), own_address, cfg_bcast_inv);
		end
		if (is_mode(f_sa(next_word)) && cfg_undef_inv
		    && is_undefined(f_tr(next_word), f_wc(next_word))) begin
			next_valid = 1'b0;
		end
		// Broadcast transmit to a subaddress has no defined meaning
		if (f_addr(next_word) == BROADCAST_TERMINAL_ADDRESS && f_tr(next_word)
		    && !is_mode(f_sa(next_word))) begin
			next_valid = 1'b0;
		end
	end

	// Sequencer: clear sweep, then one command at a time
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state       <= ST_CLEAR;
			clear_index <= 8'h00;
		end else begin
			case (state)
				ST_CLEAR: begin
					clear_index <= clear_index + 8'h01;
					if (clear_index == TABLE_LAST_INDEX) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (take) begin
						state <= ST_LOOKUP;
					end
				end
				ST_LOOKUP: state <= ST_DECIDE;
				ST_DECIDE: state <= ST_IDLE;
				default:   state <= ST_CLEAR;
			endcase
		end
	end

	// Ready flags track the sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			terminal_ready <= 1'b0;
			cmd_ready      <= 1'b0;
		end else begin
			if (state == ST_CLEAR && clear_index == TABLE_LAST_INDEX) begin
				terminal_ready <= 1'b1;
			end
			cmd_ready <= (state == ST_CLEAR && clear_index == TABLE_LAST_INDEX)
				  || state == ST_DECIDE
				  || (state == ST_IDLE && !take);
		end
	end

	// Hold the chosen word and point the table at its entry
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			held_word    <= 16'h0000;
			held_valid   <= 1'b0;
			held_terminal_to_terminal_flag    <= 1'b0;
			lookup_index <= 8'h00;
		end else if (take) begin
			held_word    <= next_word;
			held_valid   <= next_valid;
			held_terminal_to_terminal_flag    <= next_terminal_to_terminal_flag;
			// Index: own-address, T/R, subaddress, count msb
			lookup_index <= {f_addr(next_word) != BROADCAST_TERMINAL_ADDRESS,
					 f_tr(next_word), f_sa(next_word), f_wc(next_word) >= MODE_CODE_SIXTEEN};
		end
	end

	// Result strobe and flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_valid              <= 1'b0;
			accepted                  <= 1'b0;
			status_update             <= 1'b0;
			message_error             <= 1'b0;
			transmit_dir              <= 1'b0;
			mode_command              <= 1'b0;
			mode_code                 <= 5'h00;
			undefined_mode            <= 1'b0;
			reserved_mode             <= 1'b0;
			broadcast                 <= 1'b0;
			terminal_to_terminal_flag <= 1'b0;
		end else begin
			result_valid <= state == ST_DECIDE;
			if (state == ST_DECIDE) begin
				accepted                  <= held_valid;
				status_update             <= held_valid;
				message_error             <= held_valid && legal_bit;
				transmit_dir              <= held_tr;
				mode_command              <= held_mode;
				mode_code                 <= held_wc;
				undefined_mode            <= held_mode && is_undefined(held_tr, held_wc);
				reserved_mode             <= held_mode && is_reserved(held_tr, held_wc);
				broadcast                 <= f_addr(held_word) == BROADCAST_TERMINAL_ADDRESS;
				terminal_to_terminal_flag <= held_valid && held_terminal_to_terminal_flag;
			end
		end
	end

	// Words to transact and where they live
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			word_count        <= NO_WORDS;
			descriptor_index  <= 6'h00;
			mode_data_used    <= 1'b0;
			mode_data_address <= 16'h0000;
		end else if (state == ST_DECIDE) begin
			descriptor_index <= {held_tr, f_sa(held_word)};
			mode_data_used   <= held_valid && held_mode && held_wc[4];
			mode_data_address <= MODE_DATA_BASE + {11'h000, held_tr, held_wc[3:0]};
			if (!held_valid) begin
				word_count <= NO_WORDS;
			end else if (legal_bit && held_tr) begin
				word_count <= NO_WORDS;
			end else if (held_mode) begin
				word_count <= held_wc[4] ? MODE_DATA_ONE : NO_WORDS;
			end else begin
				word_count <= to_count(held_wc);
			end
		end
	end

	// Host reads: every read answers two cycles later, unmapped reads zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			read_pending     <= 1'b0;
			read_table       <= 1'b0;
			read_config      <= 16'h0000;
			host_rdata       <= 16'h0000;
			host_rdata_valid <= 1'b0;
		end else begin
			read_pending     <= host_read;
			read_table       <= host_read && host_in_table;
			read_config      <= (host_read && host_addr == REG_TERMINAL_CONFIGURATION)
					    ? terminal_configuration : 16'h0000;
			host_rdata_valid <= read_pending;
			host_rdata       <= read_table ? table_host_data : read_config;
		end
	end

	rtcc_legality_table u_table (
		.clk          (clk),
		.write_en     (table_write_en),
		.write_index  (table_write_index),
		.write_data   (table_write_data),
		.lookup_index (lookup_index),
		.lookup_data  (lookup_data),
		.host_index   (host_addr[TABLE_AW-1:0]),
		.host_data    (table_host_data)
	);

	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_FOREIGN_IGNORED: assert property (
		take && !cmd_pair && f_addr(cmd_word) != own_address
		&& f_addr(cmd_word) != BROADCAST_TERMINAL_ADDRESS |-> ##3 (result_valid && !accepted))
		else $error("command to another terminal was accepted");
	AST_BROADCAST_INVALID: assert property (
		take && !cmd_pair && cfg_bcast_inv
		&& f_addr(cmd_word) == BROADCAST_TERMINAL_ADDRESS |-> ##3 (!accepted && !status_update))
		else $error("broadcast accepted while disallowed");
	AST_FULL_COUNT: assert property (
		take && next_valid && !is_mode(f_sa(next_word)) && !f_tr(next_word)
		&& f_wc(next_word) == WORD_COUNT_FULL_CODE |-> ##3 word_count == WORD_COUNT_FULL)
		else $error("zero word count not taken as 32");
	AST_MODE_CLASS: assert property (
		take && next_valid && is_mode(f_sa(next_word)) |-> ##3 (mode_command && result_valid))
		else $error("mode command not flagged");
	AST_LOW_RX_UNDEFINED: assert property (
		take && next_valid && is_mode(f_sa(next_word)) && !f_tr(next_word)
		&& f_wc(next_word) < MODE_CODE_SIXTEEN |-> ##3 undefined_mode)
		else $error("low mode code with T/R zero not undefined");
	AST_UNDEFINED_DROPPED: assert property (
		take && !cmd_pair && cfg_undef_inv && is_mode(f_sa(cmd_word))
		&& is_undefined(f_tr(cmd_word), f_wc(cmd_word)) |-> ##3 (!accepted && !status_update))
		else $error("undefined mode answered while invalid");
	AST_ILLEGAL_NO_DATA: assert property (
		result_valid && message_error && transmit_dir |-> (word_count == NO_WORDS && status_update))
		else $error("illegal transmit still sends data");
	AST_ILLEGAL_NEEDS_BIT: assert property (
		result_valid && accepted && !message_error && transmit_dir && !mode_command
		|-> word_count != NO_WORDS)
		else $error("legal transmit lost its data words");
	AST_CLEAR_THEN_READY: assert property (
		state == ST_CLEAR && clear_index == TABLE_LAST_INDEX |=> terminal_ready && cmd_ready)
		else $error("ready not raised after table clear");
	AST_PAIR_MODE_IGNORED: assert property (
		take && cmd_pair && (is_mode(f_sa(cmd_word)) || is_mode(f_sa(cmd_word2)))
		|-> ##3 (!accepted && !status_update))
		else $error("pair with mode subaddress accepted");
	AST_PAIR_TO_BROADCAST: assert property (
		take && cmd_pair && f_addr(cmd_word2) == BROADCAST_TERMINAL_ADDRESS |-> ##3 !accepted)
		else $error("pair transmitter at broadcast accepted");
	AST_PAIR_RECEIVE_FLAG: assert property (
		take && cmd_pair && next_valid && next_terminal_to_terminal_flag |-> ##3 (terminal_to_terminal_flag && !transmit_dir))
		else $error("pair receive not flagged");

	COV_PAIR_RECEIVE: cover property (result_valid && terminal_to_terminal_flag);
	COV_ILLEGAL: cover property (result_valid && message_error);
	COV_MODE_DATA: cover property (result_valid && mode_data_used && transmit_dir);
	COV_BROADCAST: cover property (result_valid && accepted && broadcast);
endmodule : rtcc_classifier

// ### testbench/rtcc_bc_model.sv
`timescale 1ns/1ps
module rtcc_bc_model
	import rtcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        cmd_ready,
	output logic             cmd_valid,
	output logic      [15:0] cmd_word,
	output logic             cmd_pair,
	output logic      [15:0] cmd_word2
);
	// Quiet decoder output at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_word  = 16'h0000;
		cmd_pair  = 1'b0;
		cmd_word2 = 16'h0000;
	end
	// Words are already decoder-checked; a pair is the receive word then the transmit word
	task automatic issue(input logic [15:0] w1, input logic pr, input logic [15:0] w2,
		input int gap, output bit ok);
		ok = 1'b0;
		repeat (gap) @(negedge clk);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_word  = w1;
		cmd_pair  = pr;
		cmd_word2 = w2;
		// Held until an edge sees ready, bounded
		for (int i = 0; i < 20 && !ok; i++) begin
			@(posedge clk);
			ok = (cmd_ready === 1'b1);
		end
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_pair  = 1'b0;
		// Stale words would hide a late sample, so show their inverse
		cmd_word  = ~w1;
		cmd_word2 = ~w2;
	endtask : issue
endmodule : rtcc_bc_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import rtcc_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  own = 5'h00;
	logic [15:0] host_addr = 16'h0000;
	logic        host_write = 1'b0;
	logic        host_read = 1'b0;
	logic [15:0] host_wdata = 16'h0000;
	wire  [15:0] cw1, cw2, rdata;
	wire         cv, cp, rvld, trdy, crdy, res, acc, stu, me, flg, und, rsv;
	wire  [5:0]  wcnt, dix;
	wire  [4:0]  mcode;
	wire  [15:0] mda;
	wire         tdir, mcmd, bcst, mdu;
	int          fail_count = 0;
	int          n_compared = 0;
	logic [12:0] exp_q[$];
	logic [12:0] e;
	logic [15:0] exp_w[$];
	logic [15:0] ew;
	logic [4:0]  mc, sa, wc, oth;
	logic        tr, u, r;
	bit          ok;
	always #2.5 clk = ~clk;
	rtcc_bc_model i_bc (.clk(clk), .cmd_ready(crdy), .cmd_valid(cv), .cmd_word(cw1),
		.cmd_pair(cp), .cmd_word2(cw2));
	rtcc_classifier i_dut (.clk(clk), .reset_n(reset_n), .rt_address_pins(own),
		.cmd_valid(cv), .cmd_word(cw1), .cmd_pair(cp), .cmd_word2(cw2),
		.host_addr(host_addr), .host_write(host_write), .host_read(host_read),
		.host_wdata(host_wdata), .host_rdata(rdata), .host_rdata_valid(rvld),
		.terminal_ready(trdy), .cmd_ready(crdy), .result_valid(res), .accepted(acc),
		.status_update(stu), .message_error(me), .transmit_dir(tdir), .mode_command(mcmd),
		.mode_code(mcode), .undefined_mode(und), .reserved_mode(rsv), .broadcast(bcst),
		.terminal_to_terminal_flag(flg), .word_count(wcnt), .descriptor_index(dix),
		.mode_data_used(mdu), .mode_data_address(mda));
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic check(input string nm, input logic [15:0] x, input logic [15:0] s);
		n_compared++;
		if (s !== x) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask : check
	function automatic logic [15:0] mk(input logic [4:0] a, input logic t,
		input logic [4:0] s, input logic [4:0] w);
		return {a, t, s, w};
	endfunction : mk
	// Note: {check wc, check class, acc, err, flag, undef, reserved, wc}
	function automatic logic [12:0] xp(input bit cw, cl, a, m, f, uu, rr,
		input logic [5:0] w);
		return {cw, cl, a, m, f, uu, rr, w};
	endfunction : xp
	task automatic cmd(input logic [15:0] w1, input logic pr, input logic [15:0] w2,
		input logic [12:0] x);
		exp_q.push_back(x);
		// A pair transmitting here is judged on its second word
		exp_w.push_back((pr && w2[15:11] == own && !(w1[9:5] inside {MODE_SA_LOW, MODE_SA_HIGH})
			&& !(w2[9:5] inside {MODE_SA_LOW, MODE_SA_HIGH})) ? w2 : w1);
		i_bc.issue(w1, pr, w2, $urandom % 3, ok);
		if (!ok) begin
			fail_count++;
			print_verdict();
		end
	endtask : cmd
	task automatic host_wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		host_write = 1'b1;
		host_addr  = a;
		host_wdata = d;
		@(negedge clk);
		host_write = 1'b0;
	endtask : host_wr
	task automatic host_rd(input logic [15:0] a, input logic [15:0] x);
		bit got;
		got = 1'b0;
		@(negedge clk);
		host_read = 1'b1;
		host_addr = a;
		@(negedge clk);
		host_read = 1'b0;
		for (int i = 0; i < 5 && !got; i++) begin
			@(negedge clk);
			got = (rvld === 1'b1);
		end
		if (!got) begin
			fail_count++;
			print_verdict();
		end
		check("host_rdata", x, rdata);
	endtask : host_rd
	// Result watcher: oldest note against each result pulse
	always @(negedge clk) begin
		if (res === 1'b1) begin
			if (exp_q.size() == 0) check("result count", 16'h0, 16'h1);
			else begin
				e = exp_q.pop_front();
				ew = exp_w.pop_front();
				check("accepted", 16'(e[10]), 16'(acc));
				check("status_update", 16'(e[10]), 16'(stu));
				if (e[11]) check("undefined", 16'(e[7]), 16'(und));
				if (e[11]) check("reserved", 16'(e[6]), 16'(rsv));
				if (e[11]) check("message_error", 16'(e[9]), 16'(me));
				if (e[11]) check("rt_rt_flag", 16'(e[8]), 16'(flg));
				if (e[12]) check("word_count", 16'(e[5:0]), 16'(wcnt));
				check("transmit_dir", 16'(ew[CMD_TR_POS]), 16'(tdir));
				check("mode_command", 16'(ew[9:5] inside {MODE_SA_LOW, MODE_SA_HIGH}),
					16'(mcmd));
				check("mode_code", 16'(ew[4:0]), 16'(mcode));
				check("broadcast", 16'(ew[15:11] == BROADCAST_TERMINAL_ADDRESS), 16'(bcst));
				check("descriptor_index", 16'(ew[10:5]), 16'(dix));
				check("mode_data_used", 16'(e[10] && (ew[9:5] inside {MODE_SA_LOW, MODE_SA_HIGH})
					&& ew[4]), 16'(mdu));
				// Mode data base stays at its zero default here
				check("mode_data_address", 16'({ew[10], ew[3:0]}), mda);
			end
		end
	end
	initial begin
		void'($urandom(25411));
		own = 5'($urandom % 31);
		oth = (own == 5'h1e) ? 5'h00 : own + 5'h01;
		repeat (5) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		for (int i = 0; i < 400 && trdy !== 1'b1; i++) @(negedge clk);
		if (trdy !== 1'b1) begin
			fail_count++;
			print_verdict();
		end
		host_rd(REG_TERMINAL_CONFIGURATION, CFG_RESET);
		host_rd(TABLE_FIRST_ADDR, TABLE_CLEAR);
		host_rd(TABLE_LAST_ADDR, TABLE_CLEAR);
		host_rd(16'h0100, 16'h0000);
		// Subaddress commands, boundaries first
		for (int i = 0; i < 10; i++) begin
			sa = (i == 0) ? 5'h01 : (i == 1) ? 5'h1e : 5'(1 + $urandom % 30);
			wc = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom % 32);
			tr = 1'($urandom);
			cmd(mk(own, tr, sa, wc), 1'b0, 16'h0, xp(1, 1, 1, 0, 0, 0, 0,
				(wc == 0) ? WORD_COUNT_FULL : {1'b0, wc}));
		end
		cmd(mk(oth, 1'b0, 5'h05, 5'h03), 1'b0, 16'h0, xp(0, 0, 0, 0, 0, 0, 0, 0));
		// Broadcast transmit to a subaddress is never answered
		cmd(mk(BROADCAST_TERMINAL_ADDRESS, 1'b1, 5'h05, 5'h03), 1'b0, 16'h0,
			xp(1, 0, 0, 0, 0, 0, 0, NO_WORDS));
		cmd(mk(BROADCAST_TERMINAL_ADDRESS, 1'b0, 5'h05, 5'h00), 1'b0, 16'h0,
			xp(1, 1, 1, 0, 0, 0, 0, WORD_COUNT_FULL));
		host_wr(REG_TERMINAL_CONFIGURATION, 16'h0001 << CFG_BROADCAST_INVALID_POS);
		host_rd(REG_TERMINAL_CONFIGURATION, 16'h0080);
		cmd(mk(BROADCAST_TERMINAL_ADDRESS, 1'b0, 5'h05, 5'h00), 1'b0, 16'h0,
			xp(0, 0, 0, 0, 0, 0, 0, 0));
		// Every mode code, both directions, with undefined modes valid then invalid
		for (int p = 0; p < 2; p++) begin
			host_wr(REG_TERMINAL_CONFIGURATION, 16'(p) << CFG_UNDEFINED_INVALID_POS);
			for (int k = 0; k < 64; k++) begin
				tr = k[5];
				mc = k[4:0];
				u = (!tr && (mc < MODE_CODE_SIXTEEN || mc == MODE_CODE_SIXTEEN ||
					mc == MODE_CODE_18 || mc == MODE_CODE_19)) || (tr && (mc == MODE_CODE_17
					|| mc == MODE_CODE_20 || mc == MODE_CODE_21));
				r = (tr && mc >= RESERVED_LOW_FIRST && mc < MODE_CODE_SIXTEEN) ||
					mc >= RESERVED_HIGH_FIRST;
				cmd(mk(own, tr, k[1] ? MODE_SA_HIGH : MODE_SA_LOW, mc), 1'b0, 16'h0,
					xp(1, !(p && u), !(p && u), 0, 0, u, r,
					(!(p && u) && mc[4]) ? MODE_DATA_ONE : NO_WORDS));
			end
		end
		// Illegal transmit drops its data, legal neighbour keeps it
		host_wr(16'h02c2, 16'h0008);
		cmd(mk(own, 1'b1, 5'h01, 5'h03), 1'b0, 16'h0, xp(1, 1, 1, 1, 0, 0, 0, 0));
		cmd(mk(own, 1'b1, 5'h01, 5'h04), 1'b0, 16'h0, xp(1, 1, 1, 0, 0, 0, 0, 4));
		// Terminal pairs
		cmd(mk(own, 1'b0, 5'h02, 5'h02), 1'b1, mk(oth, 1'b1, 5'h03, 5'h02),
			xp(1, 1, 1, 0, 1, 0, 0, 2));
		cmd(mk(oth, 1'b0, 5'h02, 5'h05), 1'b1, mk(own, 1'b1, 5'h03, 5'h05),
			xp(1, 1, 1, 0, 0, 0, 0, 5));
		cmd(mk(own, 1'b0, 5'h00, 5'h02), 1'b1, mk(oth, 1'b1, 5'h03, 5'h02),
			xp(0, 0, 0, 0, 0, 0, 0, 0));
		cmd(mk(oth, 1'b0, 5'h02, 5'h02), 1'b1, mk(own, 1'b1, 5'h1f, 5'h02),
			xp(0, 0, 0, 0, 0, 0, 0, 0));
		// Malformed pairs: broadcast transmitter, or a transmit word first
		cmd(mk(own, 1'b0, 5'h02, 5'h02), 1'b1, mk(BROADCAST_TERMINAL_ADDRESS, 1'b1, 5'h03, 5'h02),
			xp(1, 0, 0, 0, 0, 0, 0, NO_WORDS));
		cmd(mk(own, 1'b1, 5'h02, 5'h02), 1'b1, mk(oth, 1'b1, 5'h03, 5'h02),
			xp(1, 0, 0, 0, 0, 0, 0, NO_WORDS));
		for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clk);
		if (exp_q.size() != 0) fail_count++;
		print_verdict();
	end
endmodule : tb_top
